// >>> ranging_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module ranging_peer_model #(
  parameter int id_w = ranging_pkg::id_w
) (
  // clock
  input wire logic core_clk,
  // frame events toward the node
  output logic rx_marker,
  output logic ranging,
  output logic locate,
  output logic [id_w-1:0] frame_id
);
  initial
  begin
    rx_marker = 1'b0;
    ranging = 1'b0;
    locate = 1'b0;
    frame_id = '0;
  end
  // opening frames always ask for an ack peer answers as the ack source
  // header flag of the node's own outgoing frame shares this line
  task automatic hold_flag(input logic rng);
    ranging <= rng;
  endtask
  task automatic send(input logic rng, input logic loc, input logic [id_w-1:0] id);
    @(posedge core_clk);
    rx_marker <= 1'b1;
    ranging <= rng;
    locate <= loc;
    frame_id <= id;
    @(posedge core_clk);
    rx_marker <= 1'b0;
    // released lines show the inverse, not a stale copy
    ranging <= ~rng;
    locate <= ~loc;
    frame_id <= ~id;
  endtask
endmodule
`default_nettype wire

// >>> ranging_pkg.sv
`default_nettype none
package ranging_pkg;
  localparam int cnt_w = 32;
  localparam int id_w = 8;
  // register word offsets (index*4 = byte address)
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_status = 8'h04;
  localparam logic [7:0] off_irq_stat = 8'h08;
  localparam logic [7:0] off_irq_clr = 8'h0c;
  localparam logic [7:0] off_irq_en = 8'h10;
  localparam logic [7:0] off_start = 8'h14;
  localparam logic [7:0] off_stop = 8'h18;
  localparam logic [7:0] off_snap = 8'h1c;
  localparam logic [7:0] off_snap_id = 8'h20;
  localparam logic [7:0] off_turnaround = 8'h24;
  localparam logic [7:0] off_counter = 8'h28;
  // control bits
  localparam int ctrl_run_bit = 0;
  localparam int ctrl_stop_bit = 1;
  localparam int ctrl_orig_bit = 2;
  localparam int ctrl_infra_bit = 3;
  // interrupt bits
  localparam int irq_start_bit = 0;
  localparam int irq_stop_bit = 1;
  localparam int irq_snap_bit = 2;
  localparam int irq_ind_bit = 3;
  localparam int irq_w = 4;
  localparam logic [15:0] turnaround_rst = 16'h0064;
  typedef enum logic [1:0] {st_idle, st_wait_rx, st_wait_ack, st_done} xchg_t;
endpackage
`default_nettype wire

// >>> ranging_timestamp_capture.sv
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ranging_timestamp_capture #(
  parameter int cnt_w = ranging_pkg::cnt_w,
  parameter int id_w = ranging_pkg::id_w
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // phy events, pulsed at the timing marker
  input wire logic tx_marker,
  input wire logic rx_marker,
  input wire logic phy_header_field_ranging,
  input wire logic phy_header_field_locate,
  input wire logic tx_mode,
  input wire logic [id_w-1:0] rx_frame_id,
  // mac verdict on the last snapshot frame
  input wire logic mac_verdict_valid,
  input wire logic [id_w-1:0] mac_verdict_id,
  input wire logic mac_addr_match,
  input wire logic mac_from_peer,
  // higher layer
  output logic data_ind,
  output logic data_ind_locate,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [3:0] ctrl_q, ctrl_d;
  logic [15:0] turnaround_q, turnaround_d;
  localparam int irq_w_l = ranging_pkg::irq_w;
  logic [irq_w_l-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
  logic [cnt_w-1:0] cnt_q, cnt_d, start_q, start_d, stop_q, stop_d, snap_q, snap_d;
  logic [id_w-1:0] snap_id_q, snap_id_d;
  logic snap_pend_q, snap_pend_d;
  logic running_q, running_d;
  ranging_pkg::xchg_t st_q, st_d;
  logic [31:0] rdata_q, rdata_d;
  logic ind_q, ind_d, ind_loc_q, ind_loc_d, irq_q, irq_d;

  // only header-flagged frames are ranging; receive markers ignored while sending
  logic rx_evt, tx_evt;
  assign rx_evt = rx_marker && phy_header_field_ranging && !tx_mode;
  assign tx_evt = tx_marker && phy_header_field_ranging;

  logic [irq_w_l-1:0] ev;
  logic verdict_hit;
  assign verdict_hit = mac_verdict_valid && snap_pend_q && mac_verdict_id == snap_id_q;

  ////////////////////////////////////////////////////////////////////////////
  // counter, capture and exchange sequencing
  always_comb
  begin
    cnt_d = cnt_q;
    running_d = running_q;
    start_d = start_q;
    stop_d = stop_q;
    snap_d = snap_q;
    snap_id_d = snap_id_q;
    snap_pend_d = snap_pend_q;
    st_d = st_q;
    ev = '0;
    ind_d = 1'b0;
    ind_loc_d = 1'b0;
    if (running_q)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    if (tx_evt && ctrl_q[ranging_pkg::ctrl_orig_bit] && running_q && st_q == ranging_pkg::st_idle)
    begin
      start_d = cnt_q;
      st_d = ranging_pkg::st_wait_ack;
      ev[ranging_pkg::irq_start_bit] = 1'b1;
    end
    else if (tx_evt && !ctrl_q[ranging_pkg::ctrl_orig_bit] && st_q == ranging_pkg::st_wait_rx)
    begin
      stop_d = cnt_q;
      st_d = ranging_pkg::st_done;
      ev[ranging_pkg::irq_stop_bit] = 1'b1;
    end
    if (rx_evt)
    begin
      if (!running_q)
      begin
        running_d = 1'b1;
        cnt_d = '0;
      end
      snap_d = running_q ? cnt_q : '0;
      snap_id_d = rx_frame_id;
      snap_pend_d = 1'b1;
      ev[ranging_pkg::irq_snap_bit] = 1'b1;
      if (running_q && ctrl_q[ranging_pkg::ctrl_infra_bit])
      begin
        ind_d = 1'b1;
        ind_loc_d = phy_header_field_locate;
      end
    end
    else if (verdict_hit)
    begin
      snap_pend_d = 1'b0;
      if (!ctrl_q[ranging_pkg::ctrl_orig_bit] && mac_addr_match && st_q != ranging_pkg::st_done)
      begin
        start_d = snap_q;
        st_d = ranging_pkg::st_wait_rx;
        ev[ranging_pkg::irq_start_bit] = 1'b1;
      end
      else if (ctrl_q[ranging_pkg::ctrl_orig_bit] && st_q == ranging_pkg::st_wait_ack && mac_from_peer)
      begin
        stop_d = snap_q;
        st_d = ranging_pkg::st_done;
        ev[ranging_pkg::irq_stop_bit] = 1'b1;
      end
    end
    if (ind_d)
    begin
      ev[ranging_pkg::irq_ind_bit] = 1'b1;
    end
    // software stop ends the exchange; held values stay readable
    if (reg_wr && reg_addr == ranging_pkg::off_ctrl && reg_wdata[ranging_pkg::ctrl_stop_bit])
    begin
      running_d = 1'b0;
      st_d = ranging_pkg::st_idle;
    end
    else if (reg_wr && reg_addr == ranging_pkg::off_ctrl && reg_wdata[ranging_pkg::ctrl_run_bit] && !running_q)
    begin
      running_d = 1'b1;
      cnt_d = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_comb
  begin
    ctrl_d = ctrl_q;
    turnaround_d = turnaround_q;
    irq_en_d = irq_en_q;
    irq_stat_d = irq_stat_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr)
    begin
      unique case (reg_addr)
        ranging_pkg::off_ctrl: ctrl_d = {reg_wdata[3:2], 2'b00};
        ranging_pkg::off_irq_clr: irq_stat_d = irq_stat_q & ~reg_wdata[irq_w_l-1:0];
        ranging_pkg::off_irq_en: irq_en_d = reg_wdata[irq_w_l-1:0];
        ranging_pkg::off_turnaround: turnaround_d = reg_wdata[15:0];
        default: ;
      endcase
    end
    // set wins over a same-cycle clear
    irq_stat_d = irq_stat_d | ev;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ranging_pkg::off_ctrl: rdata_d = {28'h000_0000, ctrl_q};
        ranging_pkg::off_status: rdata_d = {28'h000_0000, snap_pend_q, running_q, st_q};
        ranging_pkg::off_irq_stat: rdata_d = {28'h000_0000, irq_stat_q};
        ranging_pkg::off_irq_en: rdata_d = {28'h000_0000, irq_en_q};
        ranging_pkg::off_start: rdata_d = 32'(start_q);
        ranging_pkg::off_stop: rdata_d = 32'(stop_q);
        ranging_pkg::off_snap: rdata_d = 32'(snap_q);
        ranging_pkg::off_snap_id: rdata_d = 32'(snap_id_q);
        ranging_pkg::off_turnaround: rdata_d = {16'h0000, turnaround_q};
        ranging_pkg::off_counter: rdata_d = 32'(cnt_q);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(irq_stat_d & irq_en_d);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_q <= '0;
      turnaround_q <= ranging_pkg::turnaround_rst;
      irq_en_q <= '0;
      irq_stat_q <= '0;
      rdata_q <= '0;
      irq_q <= 1'b0;
      cnt_q <= '0;
      running_q <= 1'b0;
      start_q <= '0;
      stop_q <= '0;
      snap_q <= '0;
      snap_id_q <= '0;
      snap_pend_q <= 1'b0;
      st_q <= ranging_pkg::st_idle;
      ind_q <= 1'b0;
      ind_loc_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      turnaround_q <= turnaround_d;
      irq_en_q <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      cnt_q <= cnt_d;
      running_q <= running_d;
      start_q <= start_d;
      stop_q <= stop_d;
      snap_q <= snap_d;
      snap_id_q <= snap_id_d;
      snap_pend_q <= snap_pend_d;
      st_q <= st_d;
      ind_q <= ind_d;
      ind_loc_q <= ind_loc_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign data_ind = ind_q;
  assign data_ind_locate = ind_loc_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_tx_no_snap: assert property (@(posedge core_clk) disable iff (rst)
    (rx_marker && tx_mode) |=> !data_ind && $stable(snap_id_q))
    else $error("snapshot taken while transmitting");
  chk_first_starts: assert property (@(posedge core_clk) disable iff (rst)
    (rx_evt && !running_q) |=> running_q && snap_q == '0 && cnt_q == '0)
    else $error("first ranging frame did not start counter");
  chk_later_snap: assert property (@(posedge core_clk) disable iff (rst)
    (rx_evt && running_q) |=> snap_q == $past(cnt_q) && snap_pend_q)
    else $error("later ranging frame not snapshotted");
  chk_nonrange_ign: assert property (@(posedge core_clk) disable iff (rst)
    (rx_marker && !phy_header_field_ranging && !verdict_hit) |=> $stable(snap_q))
    else $error("non-ranging frame captured");
  chk_orig_start: assert property (@(posedge core_clk) disable iff (rst)
    (tx_evt && ctrl_q[ranging_pkg::ctrl_orig_bit] && running_q && st_q == ranging_pkg::st_idle)
    |=> start_q == $past(cnt_q) && st_q == ranging_pkg::st_wait_ack)
    else $error("originator start not captured");
  chk_resp_stop: assert property (@(posedge core_clk) disable iff (rst)
    (tx_evt && !ctrl_q[ranging_pkg::ctrl_orig_bit] && st_q == ranging_pkg::st_wait_rx
     && !(reg_wr && reg_addr == ranging_pkg::off_ctrl)) |=> stop_q == $past(cnt_q) && st_q == ranging_pkg::st_done)
    else $error("responder stop not captured");
  chk_discard: assert property (@(posedge core_clk) disable iff (rst)
    (verdict_hit && !rx_evt && !mac_addr_match && !ctrl_q[ranging_pkg::ctrl_orig_bit]) |=> $stable(start_q))
    else $error("foreign snapshot kept");
  chk_ack_check: assert property (@(posedge core_clk) disable iff (rst)
    (verdict_hit && !rx_evt && !mac_from_peer && !tx_evt) |=> $stable(stop_q))
    else $error("ack from wrong node accepted");
  chk_indicate: assert property (@(posedge core_clk) disable iff (rst)
    (rx_evt && running_q && ctrl_q[ranging_pkg::ctrl_infra_bit]) |=> data_ind ##1 !data_ind || rx_evt)
    else $error("indication missing");
  chk_ind_has_frame: assert property (@(posedge core_clk) disable iff (rst)
    data_ind |-> $past(rx_evt) && $past(running_q))
    else $error("indication without a ranging arrival");
  chk_locate_with_ind: assert property (@(posedge core_clk) disable iff (rst)
    data_ind_locate |-> data_ind)
    else $error("locate flag without indication");
  chk_snap_id_kept: assert property (@(posedge core_clk) disable iff (rst)
    rx_evt |=> snap_id_q == $past(rx_frame_id))
    else $error("snapshot identifier not stored");
  chk_resp_start: assert property (@(posedge core_clk) disable iff (rst)
    (verdict_hit && !rx_evt && !ctrl_q[ranging_pkg::ctrl_orig_bit] && mac_addr_match
     && st_q != ranging_pkg::st_done && !(reg_wr && reg_addr == ranging_pkg::off_ctrl))
    |=> start_q == $past(snap_q) && st_q == ranging_pkg::st_wait_rx)
    else $error("responder start not taken from snapshot");
  chk_orig_stop: assert property (@(posedge core_clk) disable iff (rst)
    (verdict_hit && !rx_evt && ctrl_q[ranging_pkg::ctrl_orig_bit] && mac_from_peer
     && st_q == ranging_pkg::st_wait_ack && !(reg_wr && reg_addr == ranging_pkg::off_ctrl))
    |=> stop_q == $past(snap_q) && st_q == ranging_pkg::st_done)
    else $error("originator stop not taken from ack snapshot");
  chk_stop_held: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == ranging_pkg::st_done && !(reg_wr && reg_addr == ranging_pkg::off_ctrl)) |=> $stable(stop_q))
    else $error("held stop value changed");
  chk_soft_stop: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr == ranging_pkg::off_ctrl && reg_wdata[ranging_pkg::ctrl_stop_bit])
    |=> !running_q && st_q == ranging_pkg::st_idle)
    else $error("software stop ignored");
  chk_halted_count: assert property (@(posedge core_clk) disable iff (rst)
    (!running_q && !rx_evt && !(reg_wr && reg_addr == ranging_pkg::off_ctrl)) |=> $stable(cnt_q))
    else $error("stopped counter moved");
  chk_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read answer");

endmodule
`default_nettype wire

// >>> ranging_timestamp_capture_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define check(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module ranging_timestamp_capture_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_marker = 1'b0;
  logic tx_mode = 1'b0;
  logic mac_verdict_valid = 1'b0;
  logic [7:0] mac_verdict_id = 8'h00;
  logic mac_addr_match = 1'b0;
  logic mac_from_peer = 1'b0;
  logic [31:0] reg_rdata;
  logic data_ind;
  logic data_ind_locate;
  logic irq;
  logic rx_marker;
  logic ranging;
  logic locate;
  logic [7:0] frame_id;
  logic [31:0] cyc = 32'h0000_0000;
  logic [31:0] rx_at;
  logic [31:0] tx_at;
  logic [31:0] d;
  logic [31:0] t0;
  logic [31:0] t1;
  logic [7:0] ida;
  int mismatches = 0;
  int checks_done = 0;
  int ind_cnt = 0;
  int loc_cnt = 0;
  int i0;
  int l0;
  always #5 core_clk = ~core_clk;
  ranging_timestamp_capture ranging_timestamp_capture_inst (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_marker(tx_marker), .rx_marker(rx_marker), .phy_header_field_ranging(ranging),
    .phy_header_field_locate(locate), .tx_mode(tx_mode), .rx_frame_id(frame_id),
    .mac_verdict_valid(mac_verdict_valid), .mac_verdict_id(mac_verdict_id), .mac_addr_match(mac_addr_match),
    .mac_from_peer(mac_from_peer), .data_ind(data_ind), .data_ind_locate(data_ind_locate), .irq(irq));
  ranging_peer_model ranging_peer_model_inst (.core_clk(core_clk), .rx_marker(rx_marker), .ranging(ranging),
    .locate(locate), .frame_id(frame_id));
  // marker edges and indications, counted independently of the design
  always @(posedge core_clk)
  begin
    cyc <= cyc + 32'h0000_0001;
    if (rx_marker) rx_at <= cyc;
    if (tx_marker) tx_at <= cyc;
    if (data_ind === 1'b1) ind_cnt <= ind_cnt + 1;
    if (data_ind_locate === 1'b1) loc_cnt <= loc_cnt + 1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic pulse_tx();
    @(posedge core_clk);
    tx_mode <= 1'b1;
    tx_marker <= 1'b1;
    ranging_peer_model_inst.hold_flag(1'b1);
    @(posedge core_clk);
    tx_marker <= 1'b0;
    tx_mode <= 1'b0;
    ranging_peer_model_inst.hold_flag(1'b0);
  endtask
  task automatic verdict(input logic [7:0] id, input logic m, input logic p);
    @(posedge core_clk);
    mac_verdict_valid <= 1'b1;
    mac_verdict_id <= id;
    mac_addr_match <= m;
    mac_from_peer <= p;
    @(posedge core_clk);
    mac_verdict_valid <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // bounded: a lost event must not hang the run
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    if (irq !== 1'b1)
    begin
      mismatches++;
      $display("wrong value at %0t: irq never rose", $time);
      close_out();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h5972));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(ranging_pkg::off_turnaround, d); `check(d, {16'h0000, ranging_pkg::turnaround_rst})
    wr(ranging_pkg::off_turnaround, 32'h0000_0123);
    rd(ranging_pkg::off_turnaround, d); `check(d, 32'h0000_0123)
    rd(8'h3c, d); `check(d, 32'h0000_0000)
    // masked event, then enable and clear
    wr(ranging_pkg::off_ctrl, 32'h0000_0009);
    ranging_peer_model_inst.send(1'b1, 1'b0, 8'h11);
    repeat (4) @(posedge core_clk);
    `check(irq, 1'b0)
    rd(ranging_pkg::off_irq_stat, d); `check(d[ranging_pkg::irq_snap_bit], 1'b1)
    wr(ranging_pkg::off_irq_en, 32'h0000_000f);
    repeat (2) @(posedge core_clk);
    `check(irq, 1'b1)
    wr(ranging_pkg::off_irq_clr, 32'h0000_000f);
    repeat (2) @(posedge core_clk);
    `check(irq, 1'b0)
    wr(ranging_pkg::off_ctrl, 32'h0000_0002);
    // responder exchanges, with a foreign frame, a plain frame and one heard while sending
    for (int it = 0; it < 6; it++)
    begin
      ida = 8'($urandom_range(0, 127));
      i0 = ind_cnt;
      l0 = loc_cnt;
      wr(ranging_pkg::off_ctrl, 32'h0000_0009);
      wr(ranging_pkg::off_irq_clr, 32'h0000_000f);
      ranging_peer_model_inst.send(1'b0, 1'b1, ~ida);
      @(posedge core_clk);
      tx_mode <= 1'b1;
      ranging_peer_model_inst.send(1'b1, 1'b0, ida ^ 8'h55);
      @(posedge core_clk);
      tx_mode <= 1'b0;
      ranging_peer_model_inst.send(1'b1, 1'b0, ida);
      wait_irq();
      rd(ranging_pkg::off_snap_id, d); `check(d[7:0], ida)
      verdict(ida, 1'b0, 1'b0);
      wr(ranging_pkg::off_irq_clr, 32'h0000_000f);
      ranging_peer_model_inst.send(1'b1, 1'b1, ida | 8'h80);
      wait_irq();
      rd(ranging_pkg::off_snap_id, d); `check(d[7:0], ida | 8'h80)
      verdict(ida | 8'h80, 1'b1, 1'b0);
      repeat ($urandom_range(0, 30)) @(posedge core_clk);
      pulse_tx();
      repeat (3) @(posedge core_clk);
      rd(ranging_pkg::off_start, t0);
      rd(ranging_pkg::off_stop, t1);
      `check(t1 - t0, tx_at - rx_at)
      `check(ind_cnt - i0, 2)
      `check(loc_cnt - l0, 1)
      wr(ranging_pkg::off_ctrl, 32'h0000_0002);
      rd(ranging_pkg::off_counter, t0);
      repeat (4) @(posedge core_clk);
      rd(ranging_pkg::off_counter, t1); `check(t1, t0)
    end
    // originator: start on departure, stop held from the peer's ack
    wr(ranging_pkg::off_ctrl, 32'h0000_0005);
    pulse_tx();
    wr(ranging_pkg::off_irq_clr, 32'h0000_000f);
    repeat ($urandom_range(0, 30)) @(posedge core_clk);
    ranging_peer_model_inst.send(1'b1, 1'b0, 8'h3c);
    wait_irq();
    verdict(8'h3c, 1'b1, 1'b1);
    repeat (3) @(posedge core_clk);
    rd(ranging_pkg::off_start, t0);
    rd(ranging_pkg::off_stop, t1);
    `check(t1 - t0, rx_at - tx_at)
    ranging_peer_model_inst.send(1'b1, 1'b0, 8'h40);
    verdict(8'h40, 1'b1, 1'b1);
    rd(ranging_pkg::off_stop, d); `check(d, t1)
    close_out();
  end
endmodule
`default_nettype wire
